//--- rtl/bfp_pkg.sv
// constants and types shared by the breaker failure pick-up and timer block
package bfp_pkg;

  // program cycle: thresholds, block input and timers advance once per cycle
  localparam int unsigned CLK_HZ     = 125_000_000;
  localparam int unsigned CYCLE_MS   = 5;
  localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;

  // fixed reset ratio of the current pick-up, percent of the threshold
  localparam int unsigned RESET_PCT = 97;
  localparam int unsigned FULL_PCT  = 100;

  // setting defaults; phase threshold in 0.01 xIn, residual in 0.001 xIn
  localparam logic [12:0] PH_THR_RST   = 13'h0014;
  localparam logic [15:0] RES_THR_RST  = 16'h04b0;
  localparam int unsigned RETRIP_DLY_MS = 100;
  localparam int unsigned BF_DLY_MS     = 200;
  // delays count program cycles (5 ms steps)
  localparam logic [18:0] RETRIP_DLY_RST = 19'(RETRIP_DLY_MS / CYCLE_MS);
  localparam logic [18:0] BF_DLY_RST     = 19'(BF_DLY_MS / CYCLE_MS);
  localparam logic [18:0] TMR_MAX        = 19'h7_ffff;

  typedef enum logic [1:0] {RES_OFF, RES_FIRST, RES_SECOND, RES_CALC} res_src_t;

  typedef enum logic [3:0] {
    MODE_CUR, MODE_DO, MODE_SIG, MODE_CUR_AND_DO, MODE_CUR_OR_DO,
    MODE_CUR_OR_SIG, MODE_CUR_AND_SIG, MODE_SIG_AND_DO, MODE_SIG_OR_DO,
    MODE_CUR_OR_SIG_OR_DO, MODE_CUR_AND_SIG_AND_DO
  } op_mode_t;

  typedef enum logic [2:0] {LN_ON, LN_BLOCKED, LN_TEST, LN_TEST_BLOCKED, LN_OFF} ln_mode_t;

  typedef enum logic [2:0] {
    COND_NORMAL, COND_START, COND_RETRIP, COND_BF, COND_ON, COND_BLOCKED
  } cond_t;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BLOCKED} st_t;

  // fundamental magnitudes: phases in 0.01 xIn, residuals in 0.001 xIn
  typedef struct packed {
    logic [2:0][15:0] phase;
    logic [15:0]      first_residual_input;
    logic [15:0]      second_residual_input;
    logic [15:0]      computed_residual;
  } meas_t;

  typedef struct packed {
    res_src_t    residual_source_select;
    op_mode_t    op_mode;
    logic [12:0] ph_thr;
    logic [15:0] residual_pickup_threshold;
    logic        retrip_en;
    logic [18:0] retrip_delay;
    logic [18:0] bf_delay;
  } settings_t;

  localparam settings_t SET_RST = '{RES_OFF, MODE_CUR, PH_THR_RST, RES_THR_RST,
                                    1'b1, RETRIP_DLY_RST, BF_DLY_RST};

  typedef struct packed {
    logic [19:0] tick_cnt;
    logic [1:0]  blk_s;
    logic [1:0]  do_s;
    logic [1:0]  sig_s;
    settings_t   set;
    ln_mode_t    ln;
    logic [3:0]  pu;
    st_t         st;
    logic [18:0] tmr;
    logic        start;
    logic        retrip;
    logic        bf;
    logic        blocked;
    cond_t       cond;
  } state_t;

  localparam state_t STATE_RST = '{20'h0_0000, 2'h0, 2'h0, 2'h0, SET_RST, LN_ON,
                                   4'h0, ST_IDLE, 19'h0_0000, 1'b0, 1'b0, 1'b0,
                                   1'b0, COND_NORMAL};

endpackage : bfp_pkg

//--- rtl/breaker_failure_pickup_timer.sv
// breaker failure pick-up, block sampling and retrip / breaker failure timers
//
// Summary of operation
// (RULE1) pick-up when any phase exceeds threshold
// (RULE2) release below 97 percent of threshold
// (RULE3) one threshold shared by all phases
// (RULE4) residual source: off, first, second, computed
// (RULE5) mode selects current, relay, signal combinations
// (RULE6) phase threshold 0.01 steps, default 0.20
// (RULE7) residual threshold 0.001 steps, default 1.200
// (RULE8) block input sampled once per cycle
// (RULE9) pick-up unblocked gives start and timing
// (RULE10) pick-up while blocked gives blocked only
// (RULE11) block after start clears start, releases
// (RULE12) block must arrive 5 ms before delay
// (RULE13) both timers start from one pick-up
// (RULE14) retrip plus margins shorter than failure delay
// (RULE15) retrip enable, default on, gates retrip
// (RULE16) retrip after retrip delay, default 0.100 s
// (RULE17) breaker failure after delay, default 0.200 s
// (RULE18) condition status: normal to blocked
// (RULE19) behaviour: on, blocked, test, both, off
// (RULE20) settings change while running, no halt
// (RULE21) current mode: counters clear on drop
// (RULE22) current and relay: halt until relay
// (RULE23) release clears outputs and both timers
`timescale 1ns/100ps
module breaker_failure_pickup_timer #(
  parameter int unsigned CYCLE_CLKS = bfp_pkg::CYCLE_CLKS  // clocks per program cycle
) (
  input  wire logic               clk,                     // 125 MHz clock
  input  wire logic               rst_n,                   // async reset, active low
  input  wire bfp_pkg::meas_t     meas,                    // measured magnitudes
  input  wire bfp_pkg::settings_t settings,                // active setting group
  input  wire bfp_pkg::ln_mode_t  ln_mode,                 // requested block mode
  input  wire logic               block_in,                // block from blocking matrix
  input  wire logic               dout_mon,                // monitored output relay
  input  wire logic               sig_trip,                // monitored binary signals
  output logic                    start,                   // start, level
  output logic                    retrip,                  // redundant coil retrip
  output logic                    breaker_failure_output,  // upstream trip
  output logic                    blocked,                 // blocked, level
  output bfp_pkg::cond_t          condition,               // function condition
  output bfp_pkg::ln_mode_t       behaviour                // operating behaviour
);
  import bfp_pkg::*;

  state_t r;
  state_t n;

  // hysteresis compare: pick up above the threshold, drop below 97 percent of it
  function automatic logic hyst_pu(logic prev, logic [15:0] mag, logic [15:0] thr);
    logic [23:0] m100;
    logic [23:0] t97;
    m100 = 24'(mag) * 24'(FULL_PCT);
    t97  = 24'(thr) * 24'(RESET_PCT);
    if (prev) begin
      hyst_pu = !(m100 < t97);                                     // [RULE2]
    end else begin
      hyst_pu = mag > thr;                                         // [RULE1]
    end
  endfunction : hyst_pu

  // operating mode combination of current, relay and signal criteria
  function automatic logic mode_trig(op_mode_t m, logic cur, logic dov, logic sig);
    unique case (m)
      MODE_CUR:                mode_trig = cur;                    // [RULE21]
      MODE_DO:                 mode_trig = dov;
      MODE_SIG:                mode_trig = sig;
      MODE_CUR_AND_DO:         mode_trig = cur & dov;              // [RULE22]
      MODE_CUR_OR_DO:          mode_trig = cur | dov;
      MODE_CUR_OR_SIG:         mode_trig = cur | sig;
      MODE_CUR_AND_SIG:        mode_trig = cur & sig;
      MODE_SIG_AND_DO:         mode_trig = sig & dov;
      MODE_SIG_OR_DO:          mode_trig = sig | dov;
      MODE_CUR_OR_SIG_OR_DO:   mode_trig = cur | sig | dov;
      MODE_CUR_AND_SIG_AND_DO: mode_trig = cur & sig & dov;
      default:                 mode_trig = 1'b0;                   // undefined code: inert
    endcase
  endfunction : mode_trig

  logic        tick;
  logic [15:0] res_mag;
  logic        cur_pu;
  logic        blk;
  logic        trig;
  logic [3:0]  pu_new;
  logic [15:0] ph_thr16;

  // program cycle strobe; the last clock of each cycle does all the work
  assign tick = r.tick_cnt == 20'(CYCLE_CLKS - 1);

  // residual magnitude from the selected source; off means no residual pick-up
  always_comb begin
    unique case (r.set.residual_source_select)                     // [RULE4]
      RES_FIRST:  res_mag = meas.first_residual_input;
      RES_SECOND: res_mag = meas.second_residual_input;
      RES_CALC:   res_mag = meas.computed_residual;
      RES_OFF:    res_mag = 16'h0000;
    endcase
  end

  // fresh pick-ups for this cycle; kept apart from the next-state copy so the
  // criteria never read back what the next-state process itself writes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pu_new[i] = hyst_pu(r.pu[i], meas.phase[i], {3'h0, r.set.ph_thr}); // [RULE1] [RULE3]
    end
    pu_new[3] = (r.set.residual_source_select != RES_OFF)            // [RULE4]
              & hyst_pu(r.pu[3], res_mag, r.set.residual_pickup_threshold);
  end

  // criteria for this cycle, from the freshly computed pick-ups
  assign cur_pu = |pu_new;
  assign blk    = r.blk_s[1] | (r.ln == LN_BLOCKED) | (r.ln == LN_TEST_BLOCKED);
  assign trig   = (r.ln != LN_OFF) & mode_trig(r.set.op_mode, cur_pu, r.do_s[1], r.sig_s[1]);

  // next state; pins pass two flops before the cycle logic reads them
  always_comb begin
    n          = r;
    n.blk_s    = {r.blk_s[0], block_in};
    n.do_s     = {r.do_s[0], dout_mon};
    n.sig_s    = {r.sig_s[0], sig_trip};
    n.tick_cnt = tick ? 20'h0_0000 : r.tick_cnt + 20'h0_0001;
    if (tick) begin
      // settings taken live each cycle; a group change never stops timing
      n.set = settings;                                            // [RULE20]
      n.ln  = ln_mode;                                             // [RULE19]
      n.pu  = pu_new;                                              // [RULE1]
      // block looked at once per cycle only, so it needs one cycle of lead time
      unique case (r.st)                                           // [RULE8] [RULE12]
        ST_IDLE: begin
          if (trig && blk) begin
            n.st = ST_BLOCKED;                                     // [RULE10]
          end else if (trig) begin
            n.st  = ST_START;                                      // [RULE9]
            n.tmr = 19'h0_0000;                                    // [RULE13]
          end
        end
        ST_START: begin
          if (!trig) begin
            n.st  = ST_IDLE;                                       // [RULE23] [RULE21]
            n.tmr = 19'h0_0000;
          end else if (blk) begin
            n.st  = ST_BLOCKED;                                    // [RULE11]
            n.tmr = 19'h0_0000;
          end else if (r.tmr != TMR_MAX) begin
            n.tmr = r.tmr + 19'h0_0001;                            // [RULE13]
          end
        end
        ST_BLOCKED: begin
          if (!trig) begin
            n.st = ST_IDLE;
          end
        end
      endcase
    end
    // outputs follow the state and the shared timer
    n.start   = n.st == ST_START;
    n.blocked = n.st == ST_BLOCKED;
    n.retrip  = n.start & n.set.retrip_en & (n.tmr >= n.set.retrip_delay); // [RULE15] [RULE16]
    n.bf      = n.start & (n.tmr >= n.set.bf_delay);               // [RULE17]
    // on: a current element is up but the mode combination or behaviour off still holds timing
    if (n.bf) begin
      n.cond = COND_BF;                                            // [RULE18]
    end else if (n.retrip) begin
      n.cond = COND_RETRIP;
    end else if (n.start) begin
      n.cond = COND_START;
    end else if (n.blocked) begin
      n.cond = COND_BLOCKED;
    end else if (|n.pu) begin
      n.cond = COND_ON;
    end else begin
      n.cond = COND_NORMAL;
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= STATE_RST;                                              // [RULE6] [RULE7]
    end else begin
      r <= n;
    end
  end

  assign start                  = r.start;
  assign retrip                 = r.retrip;
  assign breaker_failure_output = r.bf;
  assign blocked                = r.blocked;
  assign condition              = r.cond;
  assign behaviour              = r.ln;

  // helper for the hysteresis check on phase one
  logic ph0_below;
  assign ph0_below = 24'(meas.phase[0]) * 24'(FULL_PCT)
                   < 24'({3'h0, r.set.ph_thr}) * 24'(RESET_PCT);

  // threshold widened to the magnitude width for the checks below
  assign ph_thr16 = {3'h0, r.set.ph_thr};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pickup_phase_a: assert property (tick && !r.pu[0] && meas.phase[0] > {3'h0, r.set.ph_thr}
                                   |=> r.pu[0]) else $error("phase pick-up missed"); // [RULE1]
  hyst_hold_a: assert property (tick && r.pu[0] && !ph0_below |=> r.pu[0])
    else $error("pick-up released above reset ratio");                           // [RULE2]
  cycle_sample_a: assert property (!tick |=> $stable(r.st) && $stable(r.tmr))
    else $error("state moved between cycles");                                   // [RULE8]
  start_timer_a: assert property ($rose(start) |-> r.tmr == 19'h0_0000 && !blocked)
    else $error("start without cleared timer");                                  // [RULE9]
  blocked_quiet_a: assert property (blocked |-> !start && !retrip && !breaker_failure_output)
    else $error("blocked with outputs active");                                  // [RULE10]
  block_release_a: assert property (tick && r.st == ST_START && trig && blk
                                    |=> blocked && !start && r.tmr == 19'h0_0000)
    else $error("block did not release start");                                  // [RULE11]
  retrip_gate_a: assert property (!r.set.retrip_en |-> !retrip)
    else $error("retrip while disabled");                                        // [RULE15]
  retrip_time_a: assert property ($rose(retrip) |-> start && r.tmr >= r.set.retrip_delay
                                  && ($past(r.tmr) < r.set.retrip_delay || !$past(start)
                                  || $past(r.set.retrip_delay) != r.set.retrip_delay
                                  || !$past(r.set.retrip_en)))
    else $error("retrip at wrong time");                                         // [RULE16]
  bf_time_a: assert property ($rose(breaker_failure_output) |-> start
                              && r.tmr >= r.set.bf_delay)
    else $error("breaker failure before delay");                                 // [RULE17]
  release_clear_a: assert property (tick && r.st == ST_START && !trig
                                    |=> !start && !retrip && !breaker_failure_output
                                    && r.tmr == 19'h0_0000)
    else $error("release left outputs or timer");                                // [RULE23]

  // the other two phases share the one threshold
  pickup_ph1_a: assert property (tick && !r.pu[1] && meas.phase[1] > ph_thr16 // [RULE3]
                                 |=> r.pu[1])
    else $error("phase two pick-up missed");

  pickup_ph2_a: assert property (tick && !r.pu[2] && meas.phase[2] > ph_thr16 // [RULE3]
                                 |=> r.pu[2])
    else $error("phase three pick-up missed");

  // release once the magnitude is under the reset ratio
  hyst_drop_a: assert property (tick && r.pu[0] && ph0_below |=> !r.pu[0]) // [RULE2]
    else $error("pick-up held below reset ratio");

  // residual source off keeps the residual element down
  res_off_a: assert property (tick && r.set.residual_source_select == RES_OFF // [RULE4]
                              |=> !r.pu[3])
    else $error("residual picked up while off");

  // residual element against its own threshold
  res_pick_a: assert property (tick && r.set.residual_source_select != RES_OFF // [RULE7]
                               && !r.pu[3] && res_mag > r.set.residual_pickup_threshold
                               |=> r.pu[3])
    else $error("residual pick-up missed");

  // signal-only and relay-only modes start without any current
  sig_only_a: assert property (tick && r.set.op_mode == MODE_SIG && r.ln == LN_ON // [RULE5]
                               && r.sig_s[1] && !r.blk_s[1] && r.st == ST_IDLE
                               |=> start)
    else $error("signal mode did not start");

  do_only_a: assert property (tick && r.set.op_mode == MODE_DO && r.ln == LN_ON // [RULE5]
                              && r.do_s[1] && !r.blk_s[1] && r.st == ST_IDLE
                              |=> start)
    else $error("relay mode did not start");

  // unblocked pick-up starts with a cleared timer
  unblk_start_a: assert property (tick && r.st == ST_IDLE && trig && !blk // [RULE9]
                                  |=> start && r.tmr == 19'h0_0000)
    else $error("unblocked pick-up did not start");

  // blocked pick-up gives only the blocked indication
  blk_start_a: assert property (tick && r.st == ST_IDLE && trig && blk // [RULE10]
                                |=> blocked && !start)
    else $error("blocked pick-up started");

  blocked_hold_a: assert property (tick && r.st == ST_BLOCKED && trig // [RULE10]
                                   |=> blocked)
    else $error("blocked dropped while pick-up on");

  // one timer for both delays, advancing one step per cycle
  tmr_step_a: assert property (tick && r.st == ST_START && trig && !blk // [RULE13]
                               && r.tmr != TMR_MAX
                               |=> r.tmr == $past(r.tmr) + 19'h0_0001)
    else $error("timer did not advance");

  tmr_sat_a: assert property (r.tmr == TMR_MAX // [RULE13]
                              |=> r.tmr == TMR_MAX || r.tmr == 19'h0_0000)
    else $error("timer wrapped");

  // outputs due as soon as the timer reaches the delay
  retrip_due_a: assert property (start && r.set.retrip_en // [RULE16]
                                 && r.tmr >= r.set.retrip_delay |-> retrip)
    else $error("retrip late");

  bf_due_a: assert property (start && r.tmr >= r.set.bf_delay // [RULE17]
                             |-> breaker_failure_output)
    else $error("breaker failure late");

  // condition follows the outputs
  cond_blocked_a: assert property (blocked |-> condition == COND_BLOCKED) // [RULE18]
    else $error("condition not blocked");

  cond_normal_a: assert property (!start && !blocked && r.pu == 4'h0 // [RULE18]
                                  |-> condition == COND_NORMAL)
    else $error("condition not normal");

  // behaviour and settings are taken at the cycle edge and held in between
  behaviour_take_a: assert property (tick |=> behaviour == $past(ln_mode)) // [RULE19]
    else $error("behaviour not taken");

  settings_take_a: assert property (tick |=> r.set == $past(settings)) // [RULE20]
    else $error("settings not taken");

  settings_hold_a: assert property (!tick |=> $stable(r.set) && $stable(r.ln)) // [RULE20]
    else $error("settings moved between cycles");

  // current-only mode clears the timer the cycle the currents drop
  cur_drop_a: assert property (tick && r.set.op_mode == MODE_CUR && !cur_pu // [RULE21]
                               |=> r.st == ST_IDLE && r.tmr == 19'h0_0000)
    else $error("current drop left timer running");

  // current-and-relay mode holds timing until the relay is seen
  and_do_halt_a: assert property (tick && r.set.op_mode == MODE_CUR_AND_DO // [RULE22]
                                  && !r.do_s[1] |=> !start && r.tmr == 19'h0_0000)
    else $error("timing ran without the relay");

  start_seen_c:   cover property ($rose(start));
  retrip_seen_c:  cover property ($rose(retrip));
  bf_seen_c:      cover property ($rose(breaker_failure_output));
  blocked_seen_c: cover property ($rose(blocked));
  cond_on_c:      cover property (condition == COND_ON);

endmodule : breaker_failure_pickup_timer

//--- tb/bfp_source.sv
// far-side model: current measurement, blocking matrix and relay monitors
`timescale 1ns/100ps
module bfp_source (
  output bfp_pkg::meas_t meas,      // measured magnitudes
  output logic           block_in,  // block from blocking matrix
  output logic           dout_mon,  // monitored output relay
  output logic           sig_trip   // monitored binary signals
);
  import bfp_pkg::*;

  integer seed = 31;

  // quiet start: no current, no block, relays at rest
  initial begin
    meas = '0;
    block_in = 1'b0;
    dout_mon = 1'b0;
    sig_trip = 1'b0;
  end

  // phases not under test carry noise below the release level, so only phase w picks up
  task automatic drive(input int w, input logic [15:0] m, input logic [15:0] r,
                       input logic [2:0] bds);
    for (int i = 0; i < 3; i++) meas.phase[i] = 16'($random(seed) & 32'h0000_000f);
    meas.phase[w] = m;
    meas.first_residual_input = r;
    meas.second_residual_input = r;
    meas.computed_residual = r;
    // block always lands a full program cycle before any delay runs out
    {block_in, dout_mon, sig_trip} = bds;
  endtask : drive
endmodule : bfp_source

//--- tb/breaker_failure_pickup_timer_bench.sv
// self-checking bench for the breaker failure pick-up and timer block
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module breaker_failure_pickup_timer_bench;
  import bfp_pkg::*;

  localparam int          C      = 8;         // short program cycle keeps the run brief
  localparam logic [15:0] Z      = 16'h0000;
  localparam logic [15:0] OVER   = 16'h0015;  // just above 0.20 xIn
  localparam logic [15:0] EQ     = 16'h0014;  // at threshold, inside hysteresis
  localparam logic [15:0] UNDER  = 16'h0013;  // below 97 % of threshold
  localparam logic [15:0] R_OVER = 16'h04b1;  // just above 1.200 xIn
  typedef struct packed {op_mode_t m; res_src_t r; ln_mode_t l; logic [15:0] mag;
    logic [15:0] res; logic [2:0] bds; logic [3:0] o; cond_t c;} case_t;

  logic       clk    = 1'b0;
  logic       rst_n  = 1'b0;
  settings_t  set_in = SET_RST;
  settings_t  cfg    = SET_RST;
  ln_mode_t   ln_in  = LN_ON;
  ln_mode_t   ln     = LN_ON;
  meas_t      meas;
  logic       block_in, dout_mon, sig_trip, start, retrip, bf_out, blocked;
  cond_t      condition;
  ln_mode_t   behaviour;
  logic [3:0] ph;
  logic [9:0] q[$];
  logic [9:0] e;
  int         n_fail   = 0;
  int         n_checks = 0;
  case_t      tbl[11];

  always #4 clk = ~clk;

  breaker_failure_pickup_timer #(.CYCLE_CLKS(C)) breaker_failure_pickup_timer_i (
    .clk(clk), .rst_n(rst_n), .meas(meas), .settings(set_in), .ln_mode(ln_in),
    .block_in(block_in), .dout_mon(dout_mon), .sig_trip(sig_trip), .start(start),
    .retrip(retrip), .breaker_failure_output(bf_out), .blocked(blocked),
    .condition(condition), .behaviour(behaviour));
  bfp_source bfp_source_i (.meas(meas), .block_in(block_in), .dout_mon(dout_mon),
    .sig_trip(sig_trip));

  // mirror of the program-cycle counter; ph is 0 just after each tick edge
  always @(posedge clk or negedge rst_n)
    if (!rst_n) ph <= 4'h0;
    else ph <= (ph == 4'(C - 1)) ? 4'h0 : ph + 4'h1;

  // each tick answers the oldest noted expectation
  always @(negedge clk)
    if (rst_n && ph == 4'h0 && q.size() > 0) begin
      e = q.pop_front();
      `CHK({start, retrip, bf_out, blocked, condition, behaviour}, e)
    end

  // drive mid-cycle so the two-flop syncs settle well before the tick edge
  task automatic step(input int w, input logic [15:0] m, input logic [15:0] r,
                      input logic [2:0] bds, input logic [3:0] o, input cond_t c);
    for (int k = 0; k < 2 * C; k++) begin
      @(negedge clk);
      if (ph == 4'(C / 2)) break;
    end
    if (ph != 4'(C / 2)) begin
      n_fail++;
      give_verdict();
    end
    set_in = cfg;
    ln_in = ln;
    bfp_source_i.drive(w, m, r, bds);
    q.push_back({o, c, ln});
  endtask : step

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // a hang anywhere ends the run as a failure
  initial begin
    repeat (20000) @(negedge clk);
    n_fail++;
    give_verdict();
  end

  // main sequence: one step per program cycle
  initial begin
    tbl = '{'{MODE_DO, RES_OFF, LN_ON, Z, Z, 3'b010, 4'h8, COND_START},
      '{MODE_SIG, RES_OFF, LN_ON, Z, Z, 3'b001, 4'h8, COND_START},
      '{MODE_CUR_OR_SIG, RES_OFF, LN_ON, Z, Z, 3'b001, 4'h8, COND_START},
      '{MODE_SIG_AND_DO, RES_OFF, LN_ON, Z, Z, 3'b011, 4'h8, COND_START},
      '{MODE_CUR, RES_OFF, LN_ON, Z, R_OVER, 3'b000, 4'h0, COND_NORMAL},
      '{MODE_CUR, RES_FIRST, LN_ON, Z, R_OVER, 3'b000, 4'h8, COND_START},
      '{MODE_CUR, RES_SECOND, LN_ON, Z, R_OVER, 3'b000, 4'h8, COND_START},
      '{MODE_CUR, RES_CALC, LN_ON, Z, R_OVER, 3'b000, 4'h8, COND_START},
      '{MODE_CUR, RES_OFF, LN_BLOCKED, OVER, Z, 3'b000, 4'h1, COND_BLOCKED},
      '{MODE_CUR, RES_OFF, LN_TEST, OVER, Z, 3'b000, 4'h8, COND_START},
      '{MODE_CUR, RES_OFF, LN_OFF, OVER, Z, 3'b000, 4'h0, COND_ON}};
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    cfg.retrip_delay = 19'h0_0002;  // retrip well ahead of breaker failure
    cfg.bf_delay = 19'h0_0004;
    step(0, Z, Z, 3'b000, 4'h0, COND_NORMAL);
    step(0, EQ, Z, 3'b000, 4'h0, COND_NORMAL);
    for (int i = 0; i < 3; i++) begin
      step(i, OVER, Z, 3'b000, 4'h8, COND_START);
      step(i, UNDER, Z, 3'b000, 4'h0, COND_NORMAL);
    end
    step(1, OVER, Z, 3'b000, 4'h8, COND_START);
    step(1, OVER, Z, 3'b000, 4'h8, COND_START);
    step(1, OVER, Z, 3'b000, 4'hc, COND_RETRIP);
    step(1, OVER, Z, 3'b000, 4'hc, COND_RETRIP);
    step(1, OVER, Z, 3'b000, 4'he, COND_BF);
    step(1, EQ, Z, 3'b000, 4'he, COND_BF);
    step(1, UNDER, Z, 3'b000, 4'h0, COND_NORMAL);
    step(2, OVER, Z, 3'b100, 4'h1, COND_BLOCKED);
    step(2, OVER, Z, 3'b000, 4'h1, COND_BLOCKED);
    step(2, Z, Z, 3'b000, 4'h0, COND_NORMAL);
    step(2, OVER, Z, 3'b000, 4'h8, COND_START);
    step(2, OVER, Z, 3'b100, 4'h1, COND_BLOCKED);
    step(2, Z, Z, 3'b000, 4'h0, COND_NORMAL);
    cfg.retrip_en = 1'b0;
    step(0, Z, Z, 3'b000, 4'h0, COND_NORMAL);
    step(0, OVER, Z, 3'b000, 4'h8, COND_START);
    step(0, OVER, Z, 3'b000, 4'h8, COND_START);
    step(0, OVER, Z, 3'b000, 4'h8, COND_START);
    cfg.bf_delay = 19'h0_0002;
    step(0, OVER, Z, 3'b000, 4'ha, COND_BF);
    step(0, UNDER, Z, 3'b000, 4'h0, COND_NORMAL);
    cfg.retrip_en = 1'b1;
    cfg.bf_delay = 19'h0_0004;
    cfg.op_mode = MODE_CUR_AND_DO;
    step(0, Z, Z, 3'b000, 4'h0, COND_NORMAL);
    step(0, OVER, Z, 3'b000, 4'h0, COND_ON);
    step(0, OVER, Z, 3'b000, 4'h0, COND_ON);
    step(0, OVER, Z, 3'b010, 4'h8, COND_START);
    step(0, OVER, Z, 3'b010, 4'h8, COND_START);
    step(0, OVER, Z, 3'b010, 4'hc, COND_RETRIP);
    step(0, OVER, Z, 3'b000, 4'h0, COND_ON);
    for (int i = 0; i < 11; i++) begin
      cfg.op_mode = tbl[i].m;
      cfg.residual_source_select = tbl[i].r;
      ln = tbl[i].l;
      step(0, Z, Z, 3'b000, 4'h0, COND_NORMAL);
      step(0, tbl[i].mag, tbl[i].res, tbl[i].bds, tbl[i].o, tbl[i].c);
      step(0, Z, Z, 3'b000, 4'h0, COND_NORMAL);
    end
    for (int k = 0; k < 4 * C && q.size() > 0; k++) @(negedge clk);
    if (q.size() > 0) n_fail++;
    give_verdict();
  end
endmodule : breaker_failure_pickup_timer_bench
